// ===== logic/qdu_code_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module qdu_code_decoder (
	input  wire logic [qdu_pkg::QDU_CODE_W-1:0]   code,   // straight binary code
	output logic      [qdu_pkg::QDU_THERMO_W-1:0] thermo, // segment switches
	output logic      [qdu_pkg::QDU_R2R_W-1:0]    r2r     // ladder switches
);
	import qdu_pkg::*;
	logic [QDU_CODE_W-QDU_SEG_LSB-1:0] seg;
	assign seg = code[QDU_CODE_W-1:QDU_SEG_LSB];
	always_comb begin
		for (int i = 0; i < QDU_THERMO_W; i++) begin
			thermo[i] = (32'(seg) > i); // [RULE_01]
		end
	end
	assign r2r = code[QDU_R2R_W-1:0]; // [RULE_02]
endmodule
`default_nettype wire

// ===== logic/qdu_device.sv
`timescale 1ns/1ps
`default_nettype none
module qdu_device (
	qdu_link_if.device link,                                                  // serial link
	input  wire logic                                           por_n,         // power-on reset
	input  wire logic                                           packet_error_check, // 32-bit frames
	input  wire logic                                           power_on_condition_strap, // strap
	output logic [qdu_pkg::QDU_CH*qdu_pkg::QDU_THERMO_W-1:0]    thermo_sw,     // segment switches
	output logic [qdu_pkg::QDU_CH*qdu_pkg::QDU_R2R_W-1:0]       r2r_sw,        // ladder switches
	output logic [qdu_pkg::QDU_CH-1:0]                          vout_en,       // voltage out on
	output logic [qdu_pkg::QDU_CH-1:0]                          iout_en,       // current out on
	output logic [qdu_pkg::QDU_CH-1:0]                          vout_pulldown, // voltage pull-down
	output logic [qdu_pkg::QDU_CH*qdu_pkg::QDU_RANGE_W-1:0]     range_sel,     // range per channel
	output logic [qdu_pkg::QDU_CH*qdu_pkg::QDU_CODE_W-1:0]      readback_code  // last written code
);
	import qdu_pkg::*;

	typedef struct packed {
		logic                                   load_s1;
		logic                                   load_s2;
		logic                                   load_prev;
		logic                                   poc_s1;
		logic                                   poc_s2;
		logic                                   pec_s1;
		logic                                   pec_s2;
		logic                                   in_frame;
		logic [5:0]                             bitcnt;
		logic [31:0]                            shreg;
		logic [QDU_CH-1:0][QDU_CODE_W-1:0]      written;
		logic [QDU_CH-1:0][QDU_CODE_W-1:0]      held;
		logic [QDU_CH-1:0][QDU_CODE_W-1:0]      dac;
		logic [QDU_CH-1:0][QDU_CODE_W-1:0]      clr_code;
		logic [QDU_CH-1:0][QDU_RANGE_W-1:0]     range;
		logic [QDU_CH-1:0]                      taken;
		logic [QDU_CH-1:0]                      out_en;
		logic [QDU_CH-1:0]                      isel;
		logic [QDU_CH-1:0]                      clr_en;
	} qdu_dev_state_t;

	qdu_dev_state_t q;
	qdu_dev_state_t d;
	logic [5:0]  frame_len;
	logic [23:0] word;
	logic [2:0]  cmd;
	logic [1:0]  ch;
	logic [11:0] code;
	logic        frame_done;

	always_comb begin
		d = q;
		// strobe, strap and frame-length pin come from other domains: two flops before use
		d.load_s1   = link.load_outputs_strobe_n;
		d.load_s2   = q.load_s1;
		d.load_prev = q.load_s2;
		d.poc_s1    = power_on_condition_strap;
		d.poc_s2    = q.poc_s1;
		// frame-length pin may only change between frames; it takes effect two clocks later
		d.pec_s1    = packet_error_check;
		d.pec_s2    = q.pec_s1;
		frame_len = q.pec_s2 ? QDU_PEC_FRAME_BITS : QDU_FRAME_BITS; // [RULE_10]
		// check bits trail the word; they are not verified here
		word = q.pec_s2 ? q.shreg[31:QDU_PEC_BITS] : q.shreg[23:0]; // [RULE_10]
		cmd  = word[QDU_CMD_MSB:QDU_CMD_LSB];
		ch   = word[QDU_CH_MSB:QDU_CH_LSB];
		code = word[QDU_CODE_MSB:QDU_CODE_LSB]; // [RULE_16] [RULE_15]
		if (!link.sync_n) begin
			d.in_frame = 1'b1;
			d.shreg    = {q.shreg[30:0], link.sdi}; // [RULE_09]
			if (q.bitcnt != QDU_BITCNT_MAX) begin
				d.bitcnt = q.bitcnt + 6'h01;
			end
		end else begin
			d.in_frame = 1'b0;
			d.bitcnt   = '0;
		end
		// short or long frames are dropped without effect
		frame_done = q.in_frame && link.sync_n && (q.bitcnt == frame_len); // [RULE_17]
		if (q.load_prev && !q.load_s2) begin
			d.dac   = q.held; // [RULE_14]
			d.taken = '0;
		end else if (!q.load_s2) begin
			d.taken = '0;
		end
		if (frame_done) begin
			case (cmd)
				QDU_CMD_DAC: begin
					d.written[ch] = code; // [RULE_13] [RULE_11]
					if (!q.load_s2) begin
						d.dac[ch]  = code; // [RULE_12]
						d.held[ch] = code;
					end else if (!q.taken[ch]) begin
						d.held[ch]  = code; // [RULE_13]
						d.taken[ch] = 1'b1;
					end
				end
				QDU_CMD_CTRL: begin
					d.out_en[ch] = word[QDU_CTL_OUTEN];
					d.isel[ch]   = word[QDU_CTL_ISEL]; // [RULE_03]
					d.clr_en[ch] = word[QDU_CTL_CLREN];
					d.range[ch]  = word[QDU_CTL_RNG_H:QDU_CTL_RNG_L];
				end
				QDU_CMD_CLRCODE: begin
					d.clr_code[ch] = code;
				end
				QDU_CMD_CLEAR: begin
					for (int i = 0; i < QDU_CH; i++) begin
						if (q.clr_en[i]) begin
							d.dac[i] = q.clr_code[i]; // [RULE_07]
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// the strap is sampled continuously, so a late strap change is also followed
	always_ff @(negedge link.sclk or negedge por_n) begin
		if (!por_n) begin
			q.load_s1   <= 1'b1;
			q.load_s2   <= 1'b1;
			q.load_prev <= 1'b1;
			q.poc_s1    <= 1'b0;
			q.poc_s2    <= 1'b0;
			q.pec_s1    <= 1'b0;
			q.pec_s2    <= 1'b0;
			q.in_frame  <= 1'b0;
			q.bitcnt    <= '0;
			q.shreg     <= '0;
			q.written   <= '0;
			q.held      <= '0;
			q.dac       <= '0;
			q.clr_code  <= {QDU_CH{QDU_CLR_RESET}}; // [RULE_06]
			q.range     <= {QDU_CH{QDU_RANGE_V0_5}}; // [RULE_06]
			q.taken     <= '0;
			q.out_en    <= '0; // [RULE_06]
			q.isel      <= '0;
			q.clr_en    <= '0;
		end else begin
			q <= d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < QDU_CH; g++) begin : gen_ch
			qdu_code_decoder u_dec (
				.code   (q.dac[g]),
				.thermo (thermo_sw[g*QDU_THERMO_W +: QDU_THERMO_W]),
				.r2r    (r2r_sw[g*QDU_R2R_W +: QDU_R2R_W])
			);
			assign vout_en[g]       = q.out_en[g] & ~q.isel[g]; // [RULE_03] [RULE_04]
			assign iout_en[g]       = q.out_en[g] & q.isel[g];  // [RULE_03] [RULE_05]
			assign vout_pulldown[g] = q.poc_s2 & ~vout_en[g];   // [RULE_05] [RULE_04]
			assign range_sel[g*QDU_RANGE_W +: QDU_RANGE_W]  = q.range[g];
			assign readback_code[g*QDU_CODE_W +: QDU_CODE_W] = q.written[g];
		end
	endgenerate
endmodule
`default_nettype wire

// ===== logic/qdu_host.sv
`timescale 1ns/1ps
`default_nettype none
module qdu_host (
	input  wire logic        pclk,    // system clock
	input  wire logic        presetn, // async reset, active low
	input  wire logic        psel,    // apb select
	input  wire logic        penable, // apb access phase
	input  wire logic        pwrite,  // apb write
	input  wire logic [7:0]  paddr,   // apb byte address
	input  wire logic [31:0] pwdata,  // apb write data
	output logic      [31:0] prdata,  // apb read data
	output logic             pready,  // apb ready
	output logic             pslverr, // apb error
	qdu_link_if.host         link     // serial link
);
	import qdu_pkg::*;

	typedef struct packed {
		qdu_hstate_t st;
		logic        sclk;
		logic        sync_n;
		logic        sdi;
		logic        load_n;
		logic        pec_en;
		logic [7:0]  pec_byte;
		logic        pend;
		logic [31:0] shreg;
		logic [5:0]  len;
		logic [5:0]  bitcnt;
		logic [2:0]  gap;
		logic [9:0]  por_cnt;
		logic [31:0] rdata;
	} qdu_host_state_t;

	qdu_host_state_t q;
	qdu_host_state_t d;
	logic rise;
	logic busy;
	logic ready;

	function automatic logic addr_known(input logic [7:0] a);
		return (a == QDU_REG_TX) || (a == QDU_REG_CTRL) ||
			(a == QDU_REG_PEC) || (a == QDU_REG_STATUS);
	endfunction

	assign busy    = q.pend || (q.st != QDU_H_IDLE);
	assign ready   = (q.por_cnt == QDU_POR_WAIT);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_known(paddr);
	assign prdata  = q.rdata;

	always_comb begin
		d = q;
		d.sclk = ~q.sclk;
		// host launches data as the serial clock rises; device takes it on the fall
		rise = !q.sclk;
		if (!ready) begin
			d.por_cnt = q.por_cnt + 10'h001; // [RULE_08]
		end
		if (psel && !penable) begin
			d.rdata = '0;
			case (paddr)
				QDU_REG_CTRL:   begin
					d.rdata[QDU_CTRL_PEC]  = q.pec_en;
					d.rdata[QDU_CTRL_LOAD] = q.load_n;
				end
				QDU_REG_PEC:    d.rdata[7:0] = q.pec_byte;
				QDU_REG_STATUS: begin
					d.rdata[QDU_ST_BUSY]  = busy;
					d.rdata[QDU_ST_READY] = ready;
				end
				default:        d.rdata = '0;
			endcase
		end
		if (psel && penable && pwrite) begin
			case (paddr)
				QDU_REG_TX: begin
					if (!busy) begin
						d.pend  = 1'b1;
						d.shreg = {pwdata[23:0], q.pec_en ? q.pec_byte : 8'h00}; // [RULE_10]
						d.len   = q.pec_en ? QDU_PEC_FRAME_BITS : QDU_FRAME_BITS;
					end
				end
				QDU_REG_CTRL: begin
					d.pec_en = pwdata[QDU_CTRL_PEC];
					d.load_n = pwdata[QDU_CTRL_LOAD]; // [RULE_12] [RULE_14]
				end
				QDU_REG_PEC: d.pec_byte = pwdata[7:0];
				default: begin
				end
			endcase
		end
		case (q.st)
			QDU_H_IDLE: begin
				if (q.pend && ready && rise) begin // [RULE_08]
					d.pend   = 1'b0;
					d.sync_n = 1'b0;
					d.sdi    = q.shreg[31]; // [RULE_09]
					d.shreg  = {q.shreg[30:0], 1'b0};
					d.bitcnt = 6'h01;
					d.st     = QDU_H_SHIFT;
				end
			end
			QDU_H_SHIFT: begin
				if (rise) begin
					if (q.bitcnt == q.len) begin
						d.sync_n = 1'b1; // [RULE_17]
						d.sdi    = 1'b0;
						d.gap    = '0;
						d.st     = QDU_H_GAP;
					end else begin
						d.sdi    = q.shreg[31]; // [RULE_09]
						d.shreg  = {q.shreg[30:0], 1'b0};
						d.bitcnt = q.bitcnt + 6'h01;
					end
				end
			end
			QDU_H_GAP: begin
				if (rise) begin
					d.gap = q.gap + 3'h1;
					if (q.gap == QDU_GAP_SCLKS - 3'h1) begin
						d.st = QDU_H_IDLE;
					end
				end
			end
			default: d.st = QDU_H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.st       <= QDU_H_IDLE;
			q.sclk     <= 1'b1;
			q.sync_n   <= 1'b1;
			q.sdi      <= 1'b0;
			q.load_n   <= 1'b1;
			q.pec_en   <= 1'b0;
			q.pec_byte <= '0;
			q.pend     <= 1'b0;
			q.shreg    <= '0;
			q.len      <= QDU_FRAME_BITS;
			q.bitcnt   <= '0;
			q.gap      <= '0;
			q.por_cnt  <= '0;
			q.rdata    <= '0;
		end else begin
			q <= d;
		end
	end

	assign link.sclk                  = q.sclk;
	assign link.sync_n                = q.sync_n;
	assign link.sdi                   = q.sdi;
	assign link.load_outputs_strobe_n = q.load_n;
endmodule
`default_nettype wire

// ===== logic/qdu_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qdu_link_if;
	logic sclk;                  // serial clock, made by host
	logic sync_n;                // frame select, active low
	logic sdi;                   // serial data, MSB first
	logic load_outputs_strobe_n; // load strobe, active low
	modport host   (output sclk, output sync_n, output sdi, output load_outputs_strobe_n);
	modport device (input sclk, input sync_n, input sdi, input load_outputs_strobe_n);
endinterface
`default_nettype wire

// ===== logic/qdu_pkg.sv
// Functional notes
// (RULE_01) top four code bits drive fifteen thermometer switches
// (RULE_02) low eight code bits drive R-2R switches
// (RULE_03) per channel, current or voltage output, never both
// (RULE_04) strap low: both outputs tristate at power-up
// (RULE_05) strap high: voltage pulled down, current tristate
// (RULE_06) power-up: outputs off, range 0-5 V, clear codes zero
// (RULE_07) clear drives clear-enabled channels to their clear code
// (RULE_08) host waits 100 us after reset before writing
// (RULE_09) MSB first, one bit per falling serial clock
// (RULE_10) error checking on: 32-bit frames with eight check bits
// (RULE_11) codes are plain straight binary, no conversion
// (RULE_12) load strobe low: addressed channel updates at frame end
// (RULE_13) load strobe high: first write per channel kept
// (RULE_14) load strobe falling updates all channels from held codes
// (RULE_15) bipolar: midscale code is zero volts, low bits ignored
// (RULE_16) channel code is data bits fifteen down to four
// (RULE_17) frame acts only on select rising after full frame
`default_nettype none
package qdu_pkg;
	localparam int unsigned QDU_CH        = 4;
	localparam int unsigned QDU_CODE_W    = 12;
	localparam int unsigned QDU_THERMO_W  = 15;
	localparam int unsigned QDU_R2R_W     = 8;
	localparam int unsigned QDU_RANGE_W   = 3;
	localparam int unsigned QDU_SEG_LSB   = 8;
	// frame lengths and field positions inside the 24-bit command word
	localparam logic [5:0]  QDU_FRAME_BITS     = 6'h18;
	localparam logic [5:0]  QDU_PEC_FRAME_BITS = 6'h20;
	localparam logic [5:0]  QDU_BITCNT_MAX     = 6'h3F;
	localparam int unsigned QDU_PEC_BITS  = 8;
	localparam int unsigned QDU_CMD_MSB   = 22;
	localparam int unsigned QDU_CMD_LSB   = 20;
	localparam int unsigned QDU_CH_MSB    = 17;
	localparam int unsigned QDU_CH_LSB    = 16;
	localparam int unsigned QDU_CODE_MSB  = 15;
	localparam int unsigned QDU_CODE_LSB  = 4;
	localparam logic [2:0]  QDU_CMD_DAC     = 3'h0;
	localparam logic [2:0]  QDU_CMD_CTRL    = 3'h1;
	localparam logic [2:0]  QDU_CMD_CLRCODE = 3'h2;
	localparam logic [2:0]  QDU_CMD_CLEAR   = 3'h3;
	// channel control word bits
	localparam int unsigned QDU_CTL_OUTEN = 0;
	localparam int unsigned QDU_CTL_ISEL  = 1;
	localparam int unsigned QDU_CTL_CLREN = 2;
	localparam int unsigned QDU_CTL_RNG_L = 3;
	localparam int unsigned QDU_CTL_RNG_H = 5;
	localparam logic [2:0]  QDU_RANGE_V0_5  = 3'h0;
	localparam logic [11:0] QDU_CLR_RESET   = 12'h000;
	// host register map
	localparam logic [7:0]  QDU_REG_TX     = 8'h00;
	localparam logic [7:0]  QDU_REG_CTRL   = 8'h04;
	localparam logic [7:0]  QDU_REG_PEC    = 8'h08;
	localparam logic [7:0]  QDU_REG_STATUS = 8'h0C;
	localparam int unsigned QDU_CTRL_PEC   = 0;
	localparam int unsigned QDU_CTRL_LOAD  = 1;
	localparam int unsigned QDU_ST_BUSY    = 0;
	localparam int unsigned QDU_ST_READY   = 1;
	// timing
	localparam int unsigned QDU_CLK_MHZ      = 10;
	localparam int unsigned QDU_POR_WAIT_US  = 100;
	localparam int unsigned QDU_POR_WAIT_CYC = QDU_POR_WAIT_US * QDU_CLK_MHZ;
	localparam logic [9:0]  QDU_POR_WAIT     = QDU_POR_WAIT_CYC[9:0];
	localparam logic [2:0]  QDU_GAP_SCLKS    = 3'h3;
	typedef enum logic [1:0] {QDU_H_IDLE, QDU_H_SHIFT, QDU_H_GAP} qdu_hstate_t;
endpackage
`default_nettype wire

// ===== verif/qdu_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module qdu_link_chk (
	input wire logic        sclk,                     // serial clock
	input wire logic        sync_n,                   // frame select
	input wire logic        load_outputs_strobe_n,    // load strobe
	input wire logic        por_n,                    // power-on reset
	input wire logic        power_on_condition_strap, // strap
	input wire logic [59:0] thermo_sw,                // segment switches
	input wire logic [31:0] r2r_sw,                   // ladder switches
	input wire logic [3:0]  vout_en,                  // voltage out on
	input wire logic [3:0]  iout_en,                  // current out on
	input wire logic [3:0]  vout_pulldown             // voltage pull-down
);
	logic [5:0] cnt;
	logic [1:0] age;
	// age keeps $past up to three ticks back from reaching across a reset; the four-tick $past of the load strobe still can
	always_ff @(negedge sclk or negedge por_n) begin
		if (!por_n) begin
			cnt <= 6'h00;
			age <= 2'h0;
		end else begin
			cnt <= sync_n ? 6'h00 : cnt + 6'h01;
			age <= (age == 2'h3) ? age : age + 2'h1;
		end
	end
	default clocking cb @(negedge sclk);
	endclocking
	default disable iff (!por_n);
	property p_len;
		$rose(sync_n) && age == 2'h3 |-> cnt == 6'h18 || cnt == 6'h20;
	endproperty
	a_len: assert property (p_len) else $error("frame length wrong");
	property p_gap;
		$rose(sync_n) && age == 2'h3 |-> sync_n [*3];
	endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	property p_excl;
		(vout_en & iout_en) == 4'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("both outputs on");
	property p_pd_hi;
		age == 2'h3 && power_on_condition_strap [*3] |-> vout_pulldown == ~vout_en;
	endproperty
	a_pd_hi: assert property (p_pd_hi) else $error("pull-down wrong");
	property p_pd_lo;
		age == 2'h3 && !power_on_condition_strap [*3] |-> vout_pulldown == 4'h0;
	endproperty
	a_pd_lo: assert property (p_pd_lo) else $error("pull-down on");
	property p_therm;
		((thermo_sw[14:0] + 15'h1) & thermo_sw[14:0]) == 15'h0;
	endproperty
	a_therm: assert property (p_therm) else $error("not thermometer");
	property p_upd;
		age == 2'h3 && $changed(r2r_sw)
			&& load_outputs_strobe_n == $past(load_outputs_strobe_n, 4)
			|-> $past(sync_n) && !$past(sync_n, 2);
	endproperty
	a_upd: assert property (p_upd) else $error("ladder moved off frame end");
	property p_steady;
		age == 2'h3 && sync_n && $past(sync_n) && $past(sync_n, 2)
			&& load_outputs_strobe_n == $past(load_outputs_strobe_n, 4)
			|-> $stable(thermo_sw);
	endproperty
	a_steady: assert property (p_steady) else $error("segments moved");
	c_f24: cover property ($rose(sync_n) && cnt == 6'h18);
	c_f32: cover property ($rose(sync_n) && cnt == 6'h20);
	c_cur: cover property (iout_en != 4'h0);
endmodule
`default_nettype wire

// ===== verif/quad_dac_serial_update_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_update_logic_test import qdu_pkg::*;;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pec_dev = 1'b0, strap = 1'b1, pready, pslverr, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, cap = 32'h0, r2r_sw;
	logic [59:0] thermo_sw;
	logic [3:0]  vout_en, iout_en, vout_pd;
	logic [11:0] range_sel;
	logic [47:0] rb_code;
	logic [11:0] codes [4] = '{12'hA5C, 12'h800, 12'hFFF, 12'h001};
	int          n_fail = 0, comparisons = 0, cyc = 0;
	always #50 pclk = ~pclk;
	qdu_link_if link ();
	qdu_host qdu_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	qdu_device qdu_device_i (.link(link), .por_n(presetn), .packet_error_check(pec_dev),
		.power_on_condition_strap(strap), .thermo_sw(thermo_sw), .r2r_sw(r2r_sw),
		.vout_en(vout_en), .iout_en(iout_en), .vout_pulldown(vout_pd),
		.range_sel(range_sel), .readback_code(rb_code));
	qdu_link_chk qdu_link_chk_i (.sclk(link.sclk), .sync_n(link.sync_n),
		.load_outputs_strobe_n(link.load_outputs_strobe_n), .por_n(presetn),
		.power_on_condition_strap(strap), .thermo_sw(thermo_sw), .r2r_sw(r2r_sw),
		.vout_en(vout_en), .iout_en(iout_en), .vout_pulldown(vout_pd));
	// bits as the device would see them, for the wire order check
	always @(negedge link.sclk) if (!link.sync_n) cap <= {cap[30:0], link.sdi};
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [23:0] fw(input logic [2:0] c, input logic [1:0] ch,
		input logic [15:0] d);
		return {1'b0, c, 2'b00, ch, d};
	endfunction
	function automatic logic [14:0] th(input logic [11:0] c);
		return 15'((16'h1 << c[11:8]) - 16'h1);
	endfunction
	// waits for ready and idle, so no frame is written while one is in flight
	task automatic send(input logic [23:0] w);
		apb(1'b0, QDU_REG_STATUS, 32'h0);
		while (rd[1:0] !== 2'b10) apb(1'b0, QDU_REG_STATUS, 32'h0);
		apb(1'b1, QDU_REG_TX, {8'h00, w});
		@(negedge link.sync_n);
		@(posedge link.sync_n);
		repeat (8) @(posedge pclk);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("pulldown", vout_pd, 4'hF);
		chk("outputs", {vout_en, iout_en, range_sel}, 20'h0);
		apb(1'b0, QDU_REG_CTRL, 32'h0);
		chk("ctrl", rd, 32'h2);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {err, rd}, 33'h1_0000_0000);
		apb(1'b1, QDU_REG_CTRL, 32'h0);
		for (int g = 0; g < 4; g++) begin
			send(fw(QDU_CMD_DAC, 2'(g), {codes[g], 4'hF}));
			chk("wire", cap[23:0], fw(QDU_CMD_DAC, 2'(g), {codes[g], 4'hF}));
			chk("ladder", r2r_sw[g*8+:8], codes[g][7:0]);
			chk("segments", thermo_sw[g*15+:15], th(codes[g]));
			chk("readback", rb_code[g*12+:12], codes[g]);
		end
		send(fw(QDU_CMD_CTRL, 2'd1, 16'h0021));
		chk("voltage", {vout_en[1], iout_en[1], vout_pd[1], range_sel[5:3]}, 6'h24);
		send(fw(QDU_CMD_CTRL, 2'd1, 16'h0023));
		chk("current", {vout_en[1], iout_en[1], vout_pd[1]}, 3'b011);
		apb(1'b1, QDU_REG_CTRL, 32'h2);
		send(fw(QDU_CMD_DAC, 2'd0, 16'h1230));
		send(fw(QDU_CMD_DAC, 2'd0, 16'h4560));
		chk("held", {r2r_sw[7:0], rb_code[11:0]}, 20'h5C456);
		apb(1'b1, QDU_REG_CTRL, 32'h0);
		repeat (12) @(posedge pclk);
		chk("loaded", r2r_sw[7:0], 8'h23);
		send(fw(QDU_CMD_CTRL, 2'd3, 16'h0005));
		send(fw(QDU_CMD_CLEAR, 2'd0, 16'h0000));
		chk("cleared", {thermo_sw[59:45], r2r_sw[31:16]}, 31'h00FF);
		send(fw(QDU_CMD_CLRCODE, 2'd3, 16'h7C00));
		send(fw(QDU_CMD_CLEAR, 2'd0, 16'h0000));
		chk("clear code", {thermo_sw[59:45], r2r_sw[31:24]}, 23'h7FC0);
		apb(1'b1, QDU_REG_PEC, 32'h3C);
		apb(1'b0, QDU_REG_PEC, 32'h0);
		chk("pec byte", rd, 32'h3C);
		apb(1'b1, QDU_REG_CTRL, 32'h1);
		pec_dev <= 1'b1;
		send(fw(QDU_CMD_DAC, 2'd2, 16'h3E70));
		chk("check bits", cap, {fw(QDU_CMD_DAC, 2'd2, 16'h3E70), 8'h3C});
		chk("long frame", r2r_sw[23:16], 8'hE7);
		pec_dev <= 1'b0;
		send(fw(QDU_CMD_DAC, 2'd2, 16'h1110));
		chk("odd length", {r2r_sw[23:16], rb_code[35:24]}, 20'hE73E7);
		apb(1'b1, QDU_REG_CTRL, 32'h0);
		strap <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// long enough for the strap to pass its synchroniser and the checker to see it
		repeat (20) @(posedge pclk);
		chk("strap low", {vout_pd, vout_en, iout_en}, 12'h0);
		chk("codes", r2r_sw, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
